//--- hdl/mbf_cfg.svh
// constants of the modbus ascii slave framer
`ifndef MBF_CFG_SVH
`define MBF_CFG_SVH
`define MBF_CH_COLON   7'h3a
`define MBF_CH_CR      7'h0d
`define MBF_CH_LF      7'h0a
`define MBF_CH_DIGIT   3'h3
`define MBF_CH_LETTER  7'h37
`define MBF_MAX_DIGIT  4'h9
`define MBF_FN_RD_MULT 8'h03
`define MBF_FN_WR_ONE  8'h06
`define MBF_FN_WR_MULT 8'h10
`define MBF_FN_RD_WR   8'h17
`define MBF_CLK_HZ     200000000
`define MBF_BAUD_SLOW  9600
`define MBF_BAUD_FAST  19200
`endif

//--- hdl/mbf_pkg.sv
// types of the modbus ascii slave framer
package mbf_pkg;
  typedef enum logic [2:0] {
    MBF_RX_IDLE    = 3'b000,
    MBF_RX_ADDR_HI = 3'b001,
    MBF_RX_ADDR_LO = 3'b010,
    MBF_RX_BODY    = 3'b011,
    MBF_RX_LF      = 3'b100
  } mbf_rx_e;

  typedef enum logic [2:0] {
    MBF_TX_IDLE  = 3'b000,
    MBF_TX_COLON = 3'b001,
    MBF_TX_AD_HI = 3'b010,
    MBF_TX_AD_LO = 3'b011,
    MBF_TX_HEX   = 3'b100,
    MBF_TX_WAIT  = 3'b101,
    MBF_TX_CR    = 3'b110,
    MBF_TX_LF    = 3'b111
  } mbf_tx_e;

  typedef struct packed {
    logic [15:0] bcnt;
    logic        tick;
    mbf_rx_e     rst;
    logic        nib;
    logic [3:0]  hi;
    logic [3:0]  ad_t;
    logic [7:0]  ad;
    logic        addr_ok;
    logic [7:0]  sum;
    logic [1:0]  nbytes;
    logic [7:0]  func;
    logic [7:0]  held;
    logic        err;
    logic [7:0]  data;
    logic        data_vld;
    logic        ok;
    logic        drop;
    logic        pend;
    logic [7:0]  r_ad;
    logic [7:0]  r_func;
    mbf_tx_e     tst;
    logic [7:0]  cur;
    logic [7:0]  tsum;
    logic        thi;
    logic        tlast;
    logic        tlrc;
  } mbf_st_s;
endpackage

//--- hdl/mbf_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module mbf_buf2 #(
  parameter int W = 7
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0]   cnt;
  } mbf_buf_s;

  mbf_buf_s s_q;
  mbf_buf_s s_d;
  logic     push;
  logic     pop;

  assign in_ready_o  = (s_q.cnt != 2'h2);
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o  = s_q.d0;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    s_d = s_q;
    case ({push, pop})
      2'b10: begin
        if (s_q.cnt == 2'h0) begin
          s_d.d0 = in_data_i;
        end else begin
          s_d.d1 = in_data_i;
        end
        s_d.cnt = s_q.cnt + 2'h1;
      end
      2'b01: begin
        s_d.d0  = s_q.d1;
        s_d.cnt = s_q.cnt - 2'h1;
      end
      2'b11: begin
        if (s_q.cnt == 2'h1) begin
          s_d.d0 = in_data_i;
        end else begin
          s_d.d0 = s_q.d1;
          s_d.d1 = in_data_i;
        end
      end
      default: begin
        s_d.cnt = s_q.cnt;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- hdl/mbf_framer.sv
// modbus ascii slave framer: request decode, response encode, bit rate
//
// Summary of operation
// - every frame starts with colon 3Ah
// - address is two decimal digits, 1..99
// - own address comes from configuration input
// - every frame ends with CR then LF
// - respond only after colon and CR LF
// - colon discards partial frame, restarts assembly
// - bytes travel as two hex chars, high first
// - accept functions 03h, 06h, 10h, 17h only
// - data field content is function dependent
// - check covers bytes between colon and CR
// - sender inserts check byte before CR LF
// - check mismatch drops the frame silently
// - check is negated eight-bit byte sum
// - transmit only in answer to a request
// - bit rate 9600 or 19200, both ends equal
// - read data supplied by application after request
`timescale 1ns/1ps
`include "mbf_cfg.svh"
module mbf_framer
  import mbf_pkg::*;
#(
  parameter int CLK_HZ = `MBF_CLK_HZ
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [6:0] cfg_slave_addr_i,
  input  wire logic       baud_fast_i,
  output logic            baud_tick_o,
  input  wire logic [6:0] rx_char_i,
  input  wire logic       rx_char_valid_i,
  output logic [7:0]      rx_func_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_data_valid_o,
  output logic            rx_frame_ok_o,
  output logic            rx_frame_drop_o,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o,
  output logic            tx_busy_o,
  output logic [6:0]      tx_char_o,
  output logic            tx_char_valid_o,
  input  wire logic       tx_char_ready_i
);
  localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / `MBF_BAUD_SLOW);
  localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / `MBF_BAUD_FAST);

  mbf_st_s    s_q;
  mbf_st_s    s_d;
  logic       push;
  logic [6:0] ch;
  logic       buf_rdy;

  function automatic logic [4:0] hex_dec(input logic [6:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c[6:4] == `MBF_CH_DIGIT && c[3:0] <= `MBF_MAX_DIGIT) begin
      r = {1'b1, c[3:0]};
    end else if (c >= 7'h41 && c <= 7'h46) begin
      r = {1'b1, 4'(c - `MBF_CH_LETTER)};
    end
    return r;
  endfunction

  function automatic logic [6:0] hex_enc(input logic [3:0] n);
    logic [6:0] r;
    r = (n <= `MBF_MAX_DIGIT) ? {`MBF_CH_DIGIT, n}
                              : 7'(`MBF_CH_LETTER + {3'h0, n});
    return r;
  endfunction

  function automatic logic is_digit(input logic [6:0] c);
    return (c[6:4] == `MBF_CH_DIGIT) && (c[3:0] <= `MBF_MAX_DIGIT);
  endfunction

  function automatic logic fn_ok(input logic [7:0] f);
    return (f == `MBF_FN_RD_MULT) || (f == `MBF_FN_WR_ONE) ||
           (f == `MBF_FN_WR_MULT) || (f == `MBF_FN_RD_WR);
  endfunction

  always_comb begin
    logic [4:0] hd;
    logic [7:0] byte_v;
    logic [6:0] adv;
    hd     = hex_dec(rx_char_i);
    byte_v = {s_q.hi, hd[3:0]};
    adv    = 7'({s_q.ad_t, 3'h0}) + 7'({s_q.ad_t, 1'b0}) +
             {3'h0, rx_char_i[3:0]};
    s_d    = s_q;
    push   = 1'b0;
    ch     = 7'h00;
    s_d.data_vld = 1'b0;
    s_d.ok       = 1'b0;
    s_d.drop     = 1'b0;
    s_d.tick     = 1'b0;
    // bit rate enable for the character layer
    if (s_q.bcnt == 16'h0000) begin
      s_d.tick = 1'b1;
      s_d.bcnt = (baud_fast_i ? DIV_FAST : DIV_SLOW) - 16'h0001;
    end else begin
      s_d.bcnt = s_q.bcnt - 16'h0001;
    end

    // response encoder
    case (s_q.tst)
      MBF_TX_IDLE: begin
        if (s_q.pend) begin
          s_d.tst = MBF_TX_COLON;
        end
      end
      MBF_TX_COLON: begin
        push = 1'b1;
        ch   = `MBF_CH_COLON;
        if (buf_rdy) begin
          s_d.tst = MBF_TX_AD_HI;
        end
      end
      MBF_TX_AD_HI: begin
        push = 1'b1;
        ch   = {`MBF_CH_DIGIT, s_q.r_ad[7:4]};
        if (buf_rdy) begin
          s_d.tst = MBF_TX_AD_LO;
        end
      end
      MBF_TX_AD_LO: begin
        push = 1'b1;
        ch   = {`MBF_CH_DIGIT, s_q.r_ad[3:0]};
        if (buf_rdy) begin
          s_d.tst   = MBF_TX_HEX;
          s_d.cur   = s_q.r_func;
          s_d.tsum  = s_q.r_ad + s_q.r_func;
          s_d.thi   = 1'b1;
          s_d.tlast = 1'b0;
          s_d.tlrc  = 1'b0;
        end
      end
      MBF_TX_HEX: begin
        push = 1'b1;
        ch   = hex_enc(s_q.thi ? s_q.cur[7:4] : s_q.cur[3:0]);
        if (buf_rdy) begin
          s_d.thi = ~s_q.thi;
          if (!s_q.thi) begin
            if (s_q.tlrc) begin
              s_d.tst = MBF_TX_CR;
            end else if (s_q.tlast) begin
              s_d.cur  = 8'h00 - s_q.tsum;
              s_d.tlrc = 1'b1;
            end else begin
              s_d.tst = MBF_TX_WAIT;
            end
          end
        end
      end
      MBF_TX_WAIT: begin
        if (tx_valid_i) begin
          s_d.cur   = tx_byte_i;
          s_d.tsum  = s_q.tsum + tx_byte_i;
          s_d.tlast = tx_last_i;
          s_d.tst   = MBF_TX_HEX;
        end
      end
      MBF_TX_CR: begin
        push = 1'b1;
        ch   = `MBF_CH_CR;
        if (buf_rdy) begin
          s_d.tst = MBF_TX_LF;
        end
      end
      MBF_TX_LF: begin
        push = 1'b1;
        ch   = `MBF_CH_LF;
        if (buf_rdy) begin
          s_d.tst  = MBF_TX_IDLE;
          s_d.pend = 1'b0;
        end
      end
      default: begin
        s_d.tst = MBF_TX_IDLE;
      end
    endcase

    // request decoder
    if (rx_char_valid_i) begin
      if (rx_char_i == `MBF_CH_COLON) begin
        s_d.rst    = MBF_RX_ADDR_HI;
        s_d.err    = 1'b0;
        s_d.nib    = 1'b0;
        s_d.nbytes = 2'h0;
        s_d.sum    = 8'h00;
        s_d.drop   = (s_q.rst == MBF_RX_BODY) || (s_q.rst == MBF_RX_LF);
      end else begin
        case (s_q.rst)
          MBF_RX_IDLE: begin
            s_d.rst = MBF_RX_IDLE;
          end
          MBF_RX_ADDR_HI: begin
            s_d.ad_t = rx_char_i[3:0];
            s_d.rst  = is_digit(rx_char_i) ? MBF_RX_ADDR_LO : MBF_RX_IDLE;
          end
          MBF_RX_ADDR_LO: begin
            s_d.addr_ok = (adv == cfg_slave_addr_i) && (adv != 7'h00);
            s_d.ad      = {s_q.ad_t, rx_char_i[3:0]};
            s_d.sum     = {s_q.ad_t, rx_char_i[3:0]};
            s_d.rst     = is_digit(rx_char_i) ? MBF_RX_BODY : MBF_RX_IDLE;
          end
          MBF_RX_BODY: begin
            if (rx_char_i == `MBF_CH_CR) begin
              s_d.err = s_q.err | s_q.nib;
              s_d.rst = MBF_RX_LF;
            end else if (!hd[4]) begin
              s_d.err = 1'b1;
            end else if (!s_q.nib) begin
              s_d.hi  = hd[3:0];
              s_d.nib = 1'b1;
            end else begin
              s_d.nib = 1'b0;
              s_d.sum = s_q.sum + byte_v;
              if (s_q.nbytes == 2'h0) begin
                s_d.func = byte_v;
              end
              // last byte is held back: it is the check byte
              if (s_q.nbytes == 2'h2) begin
                s_d.data     = s_q.held;
                s_d.data_vld = 1'b1;
              end else begin
                s_d.nbytes = s_q.nbytes + 2'h1;
              end
              s_d.held = byte_v;
            end
          end
          MBF_RX_LF: begin
            s_d.rst = MBF_RX_IDLE;
            if (rx_char_i == `MBF_CH_LF && !s_q.err && s_q.sum == 8'h00 &&
                s_q.nbytes == 2'h2 && s_q.addr_ok && fn_ok(s_q.func)) begin
              s_d.ok = 1'b1;
              if (!s_d.pend) begin
                s_d.pend   = 1'b1;
                s_d.r_ad   = s_q.ad;
                s_d.r_func = s_q.func;
              end
            end else begin
              s_d.drop = 1'b1;
            end
          end
          default: begin
            s_d.rst = MBF_RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  mbf_buf2 #(
    .W (7)
  ) u_txbuf (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (ch),
    .in_valid_i  (push),
    .in_ready_o  (buf_rdy),
    .out_data_o  (tx_char_o),
    .out_valid_o (tx_char_valid_o),
    .out_ready_i (tx_char_ready_i)
  );

  assign baud_tick_o     = s_q.tick;
  assign rx_func_o       = s_q.func;
  assign rx_data_o       = s_q.data;
  assign rx_data_valid_o = s_q.data_vld;
  assign rx_frame_ok_o   = s_q.ok;
  assign rx_frame_drop_o = s_q.drop;
  assign tx_ready_o      = (s_q.tst == MBF_TX_WAIT);
  assign tx_busy_o       = s_q.pend;
endmodule

//--- testbench/mbf_framer_properties.sv
// port assertions of the framer
`timescale 1ns/1ps
module mbf_framer_properties (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       baud_fast_i,
  input wire logic       baud_tick_o,
  input wire logic [6:0] rx_char_i,
  input wire logic       rx_char_valid_i,
  input wire logic       rx_data_valid_o,
  input wire logic       rx_frame_ok_o,
  input wire logic       rx_frame_drop_o,
  input wire logic       tx_ready_o,
  input wire logic       tx_busy_o,
  input wire logic [6:0] tx_char_o,
  input wire logic       tx_char_valid_o,
  input wire logic       tx_char_ready_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_start;
    $rose(tx_busy_o);
  endsequence
  sequence s_colon;
    tx_char_valid_o && tx_char_o == 7'h3a;
  endsequence
  AST_COLON_FIRST: assert property (s_start |-> ##[1:4] s_colon)
    else $error("response not opened by colon");
  AST_OK_AFTER_LF: assert property (rx_frame_ok_o |->
    $past(rx_char_valid_i) && $past(rx_char_i) == 7'h0a)
    else $error("frame ok without line feed");
  AST_OK_BUSY: assert property (rx_frame_ok_o |-> tx_busy_o)
    else $error("good frame left no response pending");
  AST_OK_DROP: assert property (!(rx_frame_ok_o && rx_frame_drop_o))
    else $error("ok and drop together");
  AST_READY_BUSY: assert property (tx_ready_o |-> tx_busy_o)
    else $error("byte wanted with no response");
  AST_HOLD: assert property (tx_char_valid_o && !tx_char_ready_i |=>
    tx_char_valid_o && $stable(tx_char_o))
    else $error("stalled char changed");
  AST_TICK: assert property (baud_tick_o && $stable(baud_fast_i) |=>
    !baud_tick_o [*8])
    else $error("bit tick too soon");
  AST_DATA: assert property (rx_data_valid_o |-> !rx_frame_ok_o)
    else $error("data byte with frame end");
endmodule

bind mbf_framer mbf_framer_properties chk_u (.sys_clk_i, .reset_n_i,
  .baud_fast_i, .baud_tick_o, .rx_char_i, .rx_char_valid_i,
  .rx_data_valid_o, .rx_frame_ok_o, .rx_frame_drop_o, .tx_ready_o,
  .tx_busy_o, .tx_char_o, .tx_char_valid_o, .tx_char_ready_i);

//--- testbench/mbf_host_model.sv
// host model: sends requests, collects response chars
`timescale 1ns/1ps
module mbf_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  output logic [6:0]      rx_char_o,
  output logic            rx_char_valid_o,
  input  wire logic [6:0] tx_char_i,
  input  wire logic       tx_char_valid_i,
  output logic            tx_char_ready_o
);
  logic [6:0] got[$];
  logic [1:0] div_q = 2'h0;
  initial begin
    rx_char_o = 7'h00;
    rx_char_valid_o = 1'b0;
    tx_char_ready_o = 1'b1;
  end
  // slow host takes one char in four
  always @(posedge sys_clk_i) begin
    if (tx_char_valid_i && tx_char_ready_o) got.push_back(tx_char_i);
    div_q <= div_q + 2'h1;
    tx_char_ready_o <= #1 !slow_i || div_q == 2'h3;
  end
  function automatic logic [6:0] hx(input logic [3:0] n);
    return n < 4'ha ? 7'h30 + 7'(n) : 7'h37 + 7'(n);
  endfunction
  task automatic put(input logic [6:0] c);
    @(posedge sys_clk_i);
    #1 rx_char_o = c;
    rx_char_valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1 rx_char_valid_o = 1'b0;
    rx_char_o = ~c;
  endtask
  task automatic send(input int ad, input logic [7:0] b[$],
                      input logic bad, input logic tail);
    logic [7:0] s;
    s = 8'((ad / 10) * 16 + ad % 10);
    put(7'h3a);
    put(7'(8'h30 + ad / 10));
    put(7'(8'h30 + ad % 10));
    foreach (b[i]) begin
      s = s + b[i];
      put(hx(b[i][7:4]));
      put(hx(b[i][3:0]));
    end
    s = (8'h00 - s) ^ {7'h00, bad};
    put(hx(s[7:4]));
    put(hx(s[3:0]));
    if (tail) begin
      put(7'h0d);
      put(7'h0a);
    end
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench of the framer
`timescale 1ns/1ps
module tb;
  localparam int CLK_HZ = 192000;
  logic       sys_clk_i, reset_n_i, baud_fast_i, baud_tick_o, slow;
  logic [6:0] cfg_slave_addr_i, rx_char_i, tx_char_o;
  logic       rx_char_valid_i, rx_data_valid_o, rx_frame_ok_o;
  logic       rx_frame_drop_o, tx_valid_i, tx_last_i, tx_ready_o;
  logic       tx_busy_o, tx_char_valid_o, tx_char_ready_i;
  logic [7:0] rx_func_o, rx_data_o, tx_byte_i;
  logic [7:0] dq[$];
  int         errors, checked, oks, drops;

  mbf_framer #(.CLK_HZ(CLK_HZ)) dut_u (.sys_clk_i, .reset_n_i,
    .cfg_slave_addr_i, .baud_fast_i, .baud_tick_o, .rx_char_i,
    .rx_char_valid_i, .rx_func_o, .rx_data_o, .rx_data_valid_o,
    .rx_frame_ok_o, .rx_frame_drop_o, .tx_byte_i, .tx_valid_i,
    .tx_last_i, .tx_ready_o, .tx_busy_o, .tx_char_o, .tx_char_valid_o,
    .tx_char_ready_i);
  mbf_host_model host_u (.sys_clk_i, .slow_i(slow), .rx_char_o(rx_char_i),
    .rx_char_valid_o(rx_char_valid_i), .tx_char_i(tx_char_o),
    .tx_char_valid_i(tx_char_valid_o), .tx_char_ready_o(tx_char_ready_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (rx_frame_ok_o === 1'b1) oks++;
    if (rx_frame_drop_o === 1'b1) drops++;
    if (rx_data_valid_o === 1'b1) dq.push_back(rx_data_o);
  end

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input logic d);
    int n;
    for (n = 0; n < 2000 && (tx_busy_o !== d || tx_char_valid_o !== 1'b0);
         n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (n >= 2000) cmp("wait", 8'h00, 8'hff);
    if (n >= 2000) test_done();
  endtask
  task automatic give(input logic [7:0] b, input logic l);
    int n;
    @(posedge sys_clk_i);
    #1 tx_byte_i = b;
    tx_last_i = l;
    tx_valid_i = 1'b1;
    // ready is looked at settled, the byte goes at the next edge
    for (n = 0; n < 500 && tx_ready_o !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (n >= 500) cmp("ready", 8'h01, 8'h00);
    if (n >= 500) test_done();
    @(posedge sys_clk_i);
    #1 tx_valid_i = 1'b0;
  endtask
  task automatic req(input int ad, input logic [7:0] fn, input logic bad,
                     input logic ok);
    int o, d;
    logic [7:0] s;
    logic [7:0] b[$];
    logic [6:0] e[$];
    o = oks;
    d = drops;
    dq.delete();
    host_u.got.delete();
    host_u.send(ad, '{fn, 8'h00, 8'h07}, bad, 1'b1);
    repeat (3) @(posedge sys_clk_i);
    #1 cmp("ok", {7'h00, ok}, 8'(oks - o));
    if (!ok) cmp("drop", 8'h01, 8'(drops - d));
    cmp("busy", {7'h00, ok}, {7'h00, tx_busy_o});
    if (!ok) return;
    cmp("func", fn, rx_func_o);
    cmp("dcount", 8'h02, 8'(dq.size()));
    cmp("data", 8'h07, dq[1]);
    give(8'h02, 1'b0);
    give(8'hee, 1'b1);
    wt(1'b0);
    b = '{fn, 8'h02, 8'hee};
    s = 8'((ad / 10) * 16 + ad % 10);
    e = '{7'h3a, 7'(8'h30 + ad / 10), 7'(8'h30 + ad % 10)};
    foreach (b[i]) begin
      s = s + b[i];
      e.push_back(host_u.hx(b[i][7:4]));
      e.push_back(host_u.hx(b[i][3:0]));
    end
    s = 8'h00 - s;
    e.push_back(host_u.hx(s[7:4]));
    e.push_back(host_u.hx(s[3:0]));
    e.push_back(7'h0d);
    e.push_back(7'h0a);
    cmp("rlen", 8'h0d, 8'(host_u.got.size()));
    foreach (e[i])
      cmp("rchar", {1'b0, e[i]}, {1'b0, host_u.got[i]});
  endtask

  task automatic t_baud();
    int n;
    for (int f = 0; f < 2; f++) begin
      reset_n_i = 1'b0;
      baud_fast_i = f[0];
      repeat (20) @(posedge sys_clk_i);
      #1 reset_n_i = 1'b1;
      n = 0;
      for (int k = 0; k < 100; k++) begin
        @(posedge sys_clk_i);
        #1;
        if (baud_tick_o === 1'b1 && n > 0) break;
        if (baud_tick_o === 1'b1 || n > 0) n++;
      end
      #1 cmp("tick", 8'(CLK_HZ / (f ? 19200 : 9600)), 8'(n));
    end
    $display("t_baud done");
  endtask
  task automatic t_funcs();
    logic [7:0] f[4] = '{8'h03, 8'h06, 8'h10, 8'h17};
    foreach (f[i]) req(1, f[i], 1'b0, 1'b1);
    req(1, 8'h05, 1'b0, 1'b0);
    req(1, 8'h03, 1'b1, 1'b0);
    $display("t_funcs done");
  endtask
  task automatic t_addr();
    slow = 1'b0;
    cfg_slave_addr_i = 7'h63;
    req(99, 8'h10, 1'b0, 1'b1);
    req(1, 8'h03, 1'b0, 1'b0);
    cfg_slave_addr_i = 7'h01;
    $display("t_addr done");
  endtask
  task automatic t_restart();
    int o;
    o = oks;
    host_u.send(1, '{8'h03, 8'h00, 8'h07}, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk_i);
    #1 cmp("noend", 8'h00, 8'(oks - o));
    cmp("nobusy", 8'h00, {7'h00, tx_busy_o});
    o = drops;
    req(1, 8'h06, 1'b0, 1'b1);
    cmp("restart", 8'h01, 8'(drops - o));
    $display("t_restart done");
  endtask

  initial begin
    cfg_slave_addr_i = 7'h01;
    slow = 1'b1;
    tx_byte_i = 8'h00;
    tx_valid_i = 1'b0;
    tx_last_i = 1'b0;
    t_baud();
    t_funcs();
    t_restart();
    t_addr();
    test_done();
  end
endmodule
